// *** pkg/display_pkg.sv ***
// Purpose: constants for the display control and strobe block
// Assumes: one 100 MHz clock, classic Wishbone register access
package display_pkg;
  localparam int unsigned clk_hz = 100_000_000;
  localparam int unsigned display_hz = 256;
  localparam int unsigned display_div = clk_hz / display_hz;
  localparam int seg_count = 20;
  localparam int phase_count = 4;
  localparam int tap_count = 4;
  localparam logic [3:0] off_strobe_control = 4'h0;
  localparam logic [3:0] off_control_second = 4'h1;
  localparam logic [3:0] off_latch_base = 4'h4;
  localparam logic [3:0] bit_sel_hi = 4'h3;
  localparam logic [3:0] bit_sel_lo = 4'h2;
  localparam logic [3:0] bit_blank = 4'h3;
  localparam logic [3:0] bit_power_down = 4'h2;
  localparam logic [3:0] bit_four_mux = 4'h1;
  localparam logic [3:0] bit_ext_bias = 4'h0;
  localparam logic [1:0] sel_reset = 2'h0;
  localparam logic [1:0] sel_reset_write = 2'h1;
  localparam logic [1:0] sel_write = 2'h2;
  localparam logic [1:0] sel_sleep = 2'h3;
  localparam logic [1:0] pump_reset = 2'h0;
  localparam logic [2:0] second_reset = 3'h7;
  localparam logic [1:0] last_phase_four = 2'h3;
  localparam logic [1:0] last_phase_three = 2'h2;
endpackage

// *** pkg/latch_if.sv ***
`timescale 1ns/1ps
// Purpose: write and read path of the segment latch store
interface latch_if;
  logic we;
  logic [4:0] waddr;
  logic [3:0] wdata;
  logic [4:0] raddr;
  logic [3:0] rdata;
  logic [79:0] all_bits;
  modport ctrl (output we, waddr, wdata, raddr, input rdata, all_bits);
  modport mem (input we, waddr, wdata, raddr, output rdata, all_bits);
endinterface

// *** design/segment_latches.sv ***
`timescale 1ns/1ps
// Purpose: 20 four-bit segment data latches
// Assumes: synchronous write, registered read
// Notes: contents survive every reset and power down
module segment_latches (
  input wire logic clk_i,
  latch_if.mem bus
);
  logic [3:0] mem_q [20];
  logic [3:0] rdata_q;
  always_ff @(posedge clk_i) begin
    if (bus.we) begin
      mem_q[bus.waddr] <= bus.wdata;
    end
    rdata_q <= mem_q[bus.raddr];
  end
  assign bus.rdata = rdata_q;
  genvar g;
  for (g = 0; g < 20; g++) begin : g_flat
    assign bus.all_bits[4*g +: 4] = mem_q[g];
  end
endmodule // segment_latches

// *** design/display_strobe.sv ***
`timescale 1ns/1ps
// Purpose: display sequencer, bias control and strobe pin source
// Assumes: por_i is power-on reset, rst_i the system reset
// Notes: registers on classic Wishbone, one word each
module display_strobe
  import display_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic cpu_reset_i,
  input wire logic sleep_i,
  input wire logic port_b_write_pulse_i,
  input wire logic [3:0] prescaler_taps_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic strobe_o,
  output logic [19:0] segment_outputs_o,
  output logic [3:0] backplane_o,
  output logic pump_clock_o,
  output logic pump_enable_o,
  output logic regulator_enable_o,
  output logic bias_pull_down_o,
  output logic bias_oe_n_o
);
  // ----------------------------------------
  // register access
  // ----------------------------------------
  latch_if lbus ();
  logic [1:0] strobe_sel_q;
  logic [1:0] pump_sel_q;
  logic ext_bias_q;
  logic [2:0] second_q;
  logic ack_q;
  logic [31:0] rd_q;
  logic taken_q;
  logic rd_latch;
  logic [3:0] reg_idx;
  logic access;
  logic wr;
  logic wr_strobe;
  logic wr_second;
  logic wr_latch;
  logic [3:0] strobe_word;
  logic [3:0] second_word;
  logic [4:0] latch_idx;
  assign reg_idx = wb_adr_i[5:2];
  // taken_q blocks a second take while the answer is on its way
  assign access = wb_cyc_i && wb_stb_i && !taken_q && !ack_q;
  assign wr = access && wb_we_i && wb_sel_i[0];
  assign latch_idx = {1'b0, 4'(reg_idx - off_latch_base)};
  function automatic logic is_latch(input logic [3:0] idx);
    return idx >= off_latch_base;
  endfunction
  assign wr_strobe = wr && reg_idx == off_strobe_control;
  assign wr_second = wr && reg_idx == off_control_second;
  assign wr_latch = wr && is_latch(reg_idx) && latch_idx < 5'(seg_count);
  assign rd_latch = is_latch(reg_idx) && latch_idx < 5'(seg_count);
  assign strobe_word = {strobe_sel_q, pump_sel_q};
  assign second_word = {second_q, ext_bias_q};
  assign lbus.we = wr_latch;
  assign lbus.waddr = latch_idx;
  assign lbus.wdata = wb_dat_i[3:0];
  assign lbus.raddr = latch_idx < 5'(seg_count) ? latch_idx : 5'h00;
  segment_latches u_latches (
    .clk_i(clk_i),
    .bus(lbus)
  );
  // answer two cycles after the take: the latch store reads through a
  // register, and the read word must itself leave a flip-flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      taken_q <= 1'b0;
      ack_q <= 1'b0;
      rd_q <= 32'h0;
    end else begin
      taken_q <= access;
      ack_q <= taken_q;
      if (taken_q) begin
        if (rd_latch) begin
          rd_q <= {28'h0, lbus.rdata};
        end else if (reg_idx == off_strobe_control) begin
          rd_q <= {28'h0, strobe_word};
        end else if (reg_idx == off_control_second) begin
          rd_q <= {28'h0, second_word};
        end else begin
          rd_q <= 32'h0;
        end
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;
  // selector and external bias survive system reset
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      strobe_sel_q <= sel_reset;
      ext_bias_q <= 1'b0;
    end else if (wr_strobe) begin
      strobe_sel_q <= {wb_dat_i[bit_sel_hi], wb_dat_i[bit_sel_lo]};
    end else if (wr_second) begin
      ext_bias_q <= wb_dat_i[bit_ext_bias];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      pump_sel_q <= pump_reset;
      second_q <= second_reset;
    end else begin
      if (wr_strobe) begin
        pump_sel_q <= wb_dat_i[1:0];
      end
      if (wr_second) begin
        second_q <= {wb_dat_i[bit_blank], wb_dat_i[bit_power_down],
                     wb_dat_i[bit_four_mux]};
      end
    end
  end
  // ----------------------------------------
  // strobe pin
  // ----------------------------------------
  // half a system period maps to one fast cycle; falling edge
  // of that pulse is where the port b latch samples
  logic strobe_d;
  always_comb begin
    unique case (strobe_sel_q)
      sel_reset: strobe_d = cpu_reset_i;
      sel_reset_write: strobe_d = cpu_reset_i || port_b_write_pulse_i;
      sel_write: strobe_d = port_b_write_pulse_i;
      sel_sleep: strobe_d = sleep_i;
    endcase
  end
  always_ff @(posedge clk_i) begin
    strobe_o <= strobe_d;
  end
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  logic [$clog2(display_div)-1:0] div_q;
  logic tick;
  logic half_q;
  logic [1:0] phase_q;
  logic [1:0] last_phase;
  logic blank;
  logic power_down;
  logic four_mux;
  logic phase_live;
  assign blank = second_q[2];
  assign power_down = second_q[1];
  assign four_mux = second_q[0];
  assign tick = div_q == ($clog2(display_div))'(display_div - 1);
  assign last_phase = four_mux ? last_phase_four : last_phase_three;
  // a phase left over from 4:1 stays dark after a switch to 3:1
  assign phase_live = phase_q <= last_phase;
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      div_q <= '0;
      half_q <= 1'b0;
      phase_q <= 2'h0;
    end else begin
      div_q <= tick ? '0 : div_q + 1'b1;
      if (tick) begin
        half_q <= !half_q;
        if (half_q) begin
          phase_q <= phase_q >= last_phase ? 2'h0 : phase_q + 2'h1;
        end
      end
    end
  end
  logic [19:0] seg_d;
  logic [3:0] bp_d;
  genvar s;
  for (s = 0; s < seg_count; s++) begin : g_seg
    assign seg_d[s] = !blank && !power_down && phase_live &&
                      lbus.all_bits[4*s + phase_q];
  end
  for (s = 0; s < phase_count; s++) begin : g_bp
    assign bp_d[s] = !power_down && phase_q == 2'(s) &&
                     (four_mux || s != phase_count - 1);
  end
  // ----------------------------------------
  // bias and pump
  // ----------------------------------------
  logic pump_on;
  assign pump_on = !power_down && !ext_bias_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      segment_outputs_o <= 20'h0;
      backplane_o <= 4'h0;
      pump_clock_o <= 1'b0;
      pump_enable_o <= 1'b0;
      regulator_enable_o <= 1'b0;
      bias_pull_down_o <= 1'b1;
      bias_oe_n_o <= 1'b1;
    end else begin
      segment_outputs_o <= seg_d;
      backplane_o <= bp_d;
      pump_clock_o <= pump_on && prescaler_taps_i[pump_sel_q];
      pump_enable_o <= pump_on;
      regulator_enable_o <= pump_on;
      bias_pull_down_o <= power_down && !ext_bias_q;
      bias_oe_n_o <= ext_bias_q || power_down;
    end
  end
endmodule // display_strobe

// *** dv/display_strobe_asserts.sv ***
// Purpose: port checks of the display and strobe block
// Assumes: rst_i resets all but selector, external bias, latch store and strobe pin, one clock
// Notes: selector is internal, so strobe checked on quiet inputs
`timescale 1ns/1ps
module display_strobe_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cpu_reset_i,
  input wire logic sleep_i,
  input wire logic port_b_write_pulse_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic strobe_o,
  input wire logic [19:0] segment_outputs_o,
  input wire logic [3:0] backplane_o,
  input wire logic pump_clock_o,
  input wire logic pump_enable_o,
  input wire logic regulator_enable_o,
  input wire logic bias_pull_down_o,
  input wire logic bias_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence quiet_s;
    !cpu_reset_i && !sleep_i && !port_b_write_pulse_i;
  endsequence
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence pump_off_s;
    !pump_enable_o ##1 !pump_enable_o;
  endsequence
  strobe_quiet_a: assert property (quiet_s |=> !strobe_o)
    else $error("strobe high with no source");
  ack_next_a: assert property (req_s |-> ##[1:2] wb_ack_o)
    else $error("no ack after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ext_float_a: assert property (bias_oe_n_o |-> !pump_enable_o)
    else $error("pump on while bias floats");
  down_ground_a: assert property (bias_pull_down_o |->
    !pump_enable_o && !regulator_enable_o) else $error("pump on in power down");
  pump_gate_a: assert property (pump_off_s |-> !pump_clock_o)
    else $error("pump clock while pump off");
  phase_onehot_a: assert property ($onehot0(backplane_o))
    else $error("two backplanes active");
  seg_dark_a: assert property (backplane_o == 4'h0 |->
    segment_outputs_o == 20'h0) else $error("segments lit, no phase");
endmodule // display_strobe_asserts

// *** dv/port_b_latch_model.sv ***
// Purpose: external port b latch fed by the strobe pin
// Assumes: port b data held past the strobe fall
// Notes: capture seen one clock after the fall
`timescale 1ns/1ps
module port_b_latch_model (
  input wire logic clk_i,
  input wire logic strobe_i,
  input wire logic [3:0] data_i,
  output logic [3:0] latched_o
);
  logic strobe_q;
  always_ff @(posedge clk_i) begin
    strobe_q <= strobe_i;
    if (strobe_q && !strobe_i) latched_o <= data_i;
  end
endmodule // port_b_latch_model

// *** dv/lcd_control_and_strobe_output_bench.sv ***
// Purpose: self-checking bench of the display and strobe block
// Assumes: two-cycle wishbone answer, registered outputs
// Notes: sequencer too slow to run; left to the checker
`timescale 1ns/1ps
module lcd_control_and_strobe_output_bench;
  import display_pkg::*;
  localparam logic [11:0] strobe_tbl = 12'h899;
  localparam logic [5:0] a0 = {off_strobe_control, 2'b00};
  localparam logic [5:0] a1 = {off_control_second, 2'b00};
  localparam logic [5:0] al = {off_latch_base, 2'b00};
  logic clk_i = 0, rst_i = 1, por_i = 1, wb_ack_o, strobe_o;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, pump_clock_o;
  logic [2:0] src = '0;
  logic [3:0] prescaler_taps_i = '0, r, pb_data = '0, pb_latched;
  logic [5:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic [19:0] segment_outputs_o;
  logic [3:0] backplane_o;
  logic pump_enable_o, regulator_enable_o, bias_pull_down_o, bias_oe_n_o;
  int failures = 0, cmp_count = 0;
  always #5 clk_i = ~clk_i;
  display_strobe i_display_strobe (.clk_i, .rst_i, .por_i,
    .cpu_reset_i(src[0]), .port_b_write_pulse_i(src[1]), .sleep_i(src[2]),
    .prescaler_taps_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .strobe_o,
    .segment_outputs_o, .backplane_o, .pump_clock_o, .pump_enable_o,
    .regulator_enable_o, .bias_pull_down_o, .bias_oe_n_o);
  port_b_latch_model i_port_b_latch_model (.clk_i, .strobe_i(strobe_o),
    .data_i(pb_data), .latched_o(pb_latched));
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [5:0] a, input logic [3:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {28'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o[3:0];
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [3:0] e);
    wb(0, a, 4'h0);
    chk(r, e);
  endtask
  // one source for a cycle, strobe seen one cycle later
  task automatic src_chk(input int i, input logic e);
    @(posedge clk_i);
    src <= 3'(1 << i);
    @(posedge clk_i);
    src <= '0;
    #1 chk({3'b000, strobe_o}, {3'b000, e});
    @(posedge clk_i);
    #1 chk({3'b000, strobe_o}, 4'h0);
  endtask
  task automatic t_reset_values;
    src_chk(0, 1);
    rd_chk(a0, 4'h0);
    rd_chk(a1, 4'he);
    rd_chk(6'h08, 4'h0);
  endtask
  task automatic t_strobe_sel;
    for (int s = 0; s < 4; s++) begin
      wb(1, a0, {2'(s), 2'b00});
      for (int i = 0; i < 3; i++) src_chk(i, strobe_tbl[s*3+i]);
    end
  endtask
  task automatic t_sys_reset;
    wb(1, a0, 4'hb);
    wb(1, a1, 4'h1);
    @(posedge clk_i);
    rst_i <= 1;
    @(posedge clk_i);
    rst_i <= 0;
    rd_chk(a0, 4'h8);
    rd_chk(a1, 4'hf);
    chk({2'b00, bias_oe_n_o, pump_enable_o}, 4'h2);
    // a write without its low byte lane must leave the register alone
    wb_sel_i <= 4'he;
    wb(1, a1, 4'h0);
    wb_sel_i <= 4'hf;
    rd_chk(a1, 4'hf);
  endtask
  task automatic t_power;
    wb(1, al, 4'hb);
    wb(1, a1, 4'h2);
    repeat (4) @(posedge clk_i);
    #1 chk({pump_enable_o, regulator_enable_o, bias_oe_n_o,
      bias_pull_down_o}, 4'hc);
    chk(backplane_o, 4'h1);
    chk({3'b000, segment_outputs_o[0]}, 4'h1);
    for (int s = 0; s < 4; s++) begin
      wb(1, a0, {2'b10, 2'(s)});
      prescaler_taps_i <= 4'(1 << s);
      repeat (4) @(posedge clk_i);
      #1 chk({3'b000, pump_clock_o}, 4'h1);
      prescaler_taps_i <= ~4'(1 << s);
      repeat (4) @(posedge clk_i);
      #1 chk({3'b000, pump_clock_o}, 4'h0);
    end
    wb(1, a1, 4'h6);
    repeat (4) @(posedge clk_i);
    #1 chk({1'b0, pump_enable_o, regulator_enable_o, bias_pull_down_o},
      4'h1);
    chk({3'b000, segment_outputs_o[0]}, 4'h0);
    chk(backplane_o, 4'h0);
    rd_chk(al, 4'hb);
  endtask
  // software blink: blank toggled by hand, pump kept running
  task automatic t_blink;
    for (int k = 0; k < 2; k++) begin
      wb(1, a1, 4'ha);
      repeat (3) @(posedge clk_i);
      #1 chk({pump_enable_o, segment_outputs_o[0], backplane_o[0], 1'b0},
        4'ha);
      wb(1, a1, 4'h2);
      repeat (3) @(posedge clk_i);
      #1 chk({pump_enable_o, segment_outputs_o[0], backplane_o[0], 1'b0},
        4'he);
    end
  endtask
  task automatic t_port_b;
    @(posedge clk_i);
    pb_data <= 4'h5;
    src <= 3'b010;
    @(posedge clk_i);
    src <= '0;
    repeat (3) @(posedge clk_i);
    pb_data <= 4'h3;
    #1 chk(pb_latched, 4'h5);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    por_i <= 0;
    t_reset_values();
    t_strobe_sel();
    t_sys_reset();
    t_power();
    t_blink();
    t_port_b();
    report_and_stop();
  end
  initial begin
    #50000;
    failures++;
    report_and_stop();
  end
endmodule // lcd_control_and_strobe_output_bench
bind display_strobe display_strobe_asserts i_display_strobe_asserts (
  .clk_i, .rst_i, .cpu_reset_i, .sleep_i, .port_b_write_pulse_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .strobe_o, .segment_outputs_o, .backplane_o,
  .pump_clock_o, .pump_enable_o, .regulator_enable_o, .bias_pull_down_o,
  .bias_oe_n_o);
